// ### integrated_request_controller_chan_if.sv
`timescale 1ns/1ps
// Connects one channel qualifier to the controller core
interface integrated_request_controller_chan_if;
    logic sample_en;
    logic request_in;
    integrated_request_controller_pkg::integrated_request_controller_trig_t mode;
    logic hit;
    modport core (output sample_en, output request_in, output mode, input hit);
    modport qual (input sample_en, input request_in, input mode, output hit);
endinterface

// ### integrated_request_controller_chan_qual.sv
`timescale 1ns/1ps
`include "integrated_request_controller_consts.svh"
// Per-channel sampler and trigger qualifier
module integrated_request_controller_chan_qual #(
    parameter int LEVEL_SAMPLES = `INTEGRATED_REQUEST_CONTROLLER_LEVEL_SAMPLES,
    parameter int PRIOR_SAMPLES = `INTEGRATED_REQUEST_CONTROLLER_EDGE_PRIOR_SAMPLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Channel link
    integrated_request_controller_chan_if.qual ch
);
    localparam int CW = $clog2(LEVEL_SAMPLES + PRIOR_SAMPLES + 2) + 1;
    localparam logic [CW-1:0] LVL_N = CW'(LEVEL_SAMPLES);
    localparam logic [CW-1:0] PRI_N = CW'(PRIOR_SAMPLES);
    // Run counters saturate at the larger of the two counts so both tests stay reachable
    localparam int MAX_N = (LEVEL_SAMPLES > PRIOR_SAMPLES) ? LEVEL_SAMPLES : PRIOR_SAMPLES;
    localparam logic [CW-1:0] SAT_N = CW'(MAX_N);

    logic [CW-1:0] hi_run_reg, hi_run_next; // Consecutive high samples
    logic [CW-1:0] lo_run_reg, lo_run_next; // Consecutive low samples
    logic armed_reg, armed_next; // Opposite level seen long enough
    logic hit_reg, hit_next; // One-cycle qualified trigger

    // Run counters, edge arming and qualification
    always_comb begin
        hi_run_next = hi_run_reg;
        lo_run_next = lo_run_reg;
        armed_next = armed_reg;
        hit_next = 1'b0;
        if (ch.sample_en) begin
            if (ch.request_in) begin
                hi_run_next = (hi_run_reg == SAT_N) ? hi_run_reg : hi_run_reg + 1'b1;
                lo_run_next = '0;
            end else begin
                lo_run_next = (lo_run_reg == SAT_N) ? lo_run_reg : lo_run_reg + 1'b1;
                hi_run_next = '0;
            end
            case (ch.mode)
                integrated_request_controller_pkg::INTEGRATED_REQUEST_CONTROLLER_TRIG_HIGH: begin
                    hit_next = ch.request_in && (hi_run_reg + 1'b1 >= LVL_N);
                end
                integrated_request_controller_pkg::INTEGRATED_REQUEST_CONTROLLER_TRIG_LOW: begin
                    hit_next = !ch.request_in && (lo_run_reg + 1'b1 >= LVL_N);
                end
                integrated_request_controller_pkg::INTEGRATED_REQUEST_CONTROLLER_TRIG_RISE: begin
                    hit_next = ch.request_in && armed_reg;
                    armed_next = !ch.request_in && (lo_run_reg + 1'b1 >= PRI_N);
                    if (ch.request_in) armed_next = 1'b0;
                    else if (armed_reg) armed_next = 1'b1;
                end
                integrated_request_controller_pkg::INTEGRATED_REQUEST_CONTROLLER_TRIG_FALL: begin
                    hit_next = !ch.request_in && armed_reg;
                    armed_next = ch.request_in && (hi_run_reg + 1'b1 >= PRI_N);
                    if (!ch.request_in) armed_next = 1'b0;
                    else if (armed_reg) armed_next = 1'b1;
                end
                default: hit_next = 1'b0;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hi_run_reg <= '0;
            lo_run_reg <= '0;
            armed_reg <= 1'b0;
            hit_reg <= 1'b0;
        end else begin
            hi_run_reg <= hi_run_next;
            lo_run_reg <= lo_run_next;
            armed_reg <= armed_next;
            hit_reg <= hit_next;
        end
    end

    assign ch.hit = hit_reg;
endmodule

// ### integrated_request_controller_checker.sv
`timescale 1ns/1ps
// Watches the register port and the level lines
module integrated_request_controller_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic [5:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // Requests and level
    input wire logic [15:1] request_in,
    input wire logic [3:0] request_level_lines
);
    logic rd_reg; // Read taken at last edge
    logic [5:0] addr_reg; // Offset of that read
    logic out_mask_reg; // Copy of the output mask bit
    // Follows reads and the output mask bit
    always_ff @(posedge clock) begin
        rd_reg <= !sys_rst && reg_sel && !reg_wr;
        addr_reg <= reg_addr;
        if (sys_rst || (reg_sel && reg_wr && reg_addr == 6'h10)) begin
            out_mask_reg <= !sys_rst && reg_wdata[0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    rdata_idle_a: assert property (!rd_reg |-> reg_rdata == 32'h0)
        else $error("read data not idle");
    reset_clear_a: assert property ($fell(sys_rst) |-> request_level_lines == 4'h0 && reg_rdata == 32'h0)
        else $error("outputs not clear after reset");
    wo_read_a: assert property (rd_reg && addr_reg inside {6'h00, 6'h04, 6'h0C, 6'h10} |-> reg_rdata == 32'h0)
        else $error("write-only register read nonzero");
    pend_read_a: assert property (rd_reg && addr_reg == 6'h08 |-> reg_rdata[31:16] == 16'h0 && !reg_rdata[0])
        else $error("pending view reserved bits set");
    level_read_a: assert property (rd_reg && addr_reg == 6'h14 |-> reg_rdata[31:4] == 28'h0)
        else $error("level read upper bits set");
    out_mask_a: assert property (out_mask_reg |-> request_level_lines == 4'h0)
        else $error("level lines not masked");
    level_clear_a: assert property (reg_sel && reg_wr && reg_addr == 6'h14 && reg_wdata[4]
        |-> ##[1:3] request_level_lines == 4'h0) else $error("level latch not cleared");
    level_hold_a: assert property (request_level_lines != 4'h0 && $past(request_level_lines) != 4'h0
        |-> request_level_lines >= $past(request_level_lines)) else $error("level dropped without clear");
    // Main scenarios
    cover property (rd_reg && addr_reg == 6'h14 && reg_rdata != 32'h0);
    cover property (request_level_lines == 4'hF);
    cover property (out_mask_reg && rd_reg && addr_reg == 6'h08);
endmodule
bind integrated_request_controller_ctrl integrated_request_controller_checker chk_i (.clock(clock), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .request_in(request_in),
    .request_level_lines(request_level_lines));

// ### integrated_request_controller_consts.svh
`ifndef INTEGRATED_REQUEST_CONTROLLER_CONSTS_SVH
`define INTEGRATED_REQUEST_CONTROLLER_CONSTS_SVH

// Register word offsets in the alternate space (byte addresses)
`define INTEGRATED_REQUEST_CONTROLLER_OFF_TRIG_UPPER 6'h00
`define INTEGRATED_REQUEST_CONTROLLER_OFF_TRIG_LOWER 6'h04
`define INTEGRATED_REQUEST_CONTROLLER_OFF_PEND_VIEW 6'h08
`define INTEGRATED_REQUEST_CONTROLLER_OFF_PEND_CLEAR 6'h0C
`define INTEGRATED_REQUEST_CONTROLLER_OFF_MASK 6'h10
`define INTEGRATED_REQUEST_CONTROLLER_OFF_LEVEL 6'h14

// Field positions
`define INTEGRATED_REQUEST_CONTROLLER_MASK_OUT_BIT 0
`define INTEGRATED_REQUEST_CONTROLLER_LEVEL_CLR_BIT 4

// Reset values
`define INTEGRATED_REQUEST_CONTROLLER_RST_TRIG 16'h0000
`define INTEGRATED_REQUEST_CONTROLLER_RST_MASK 16'h0000
`define INTEGRATED_REQUEST_CONTROLLER_RST_PEND 15'h0000
`define INTEGRATED_REQUEST_CONTROLLER_RST_LEVEL 4'h0

// Sampling defaults
`define INTEGRATED_REQUEST_CONTROLLER_SAMPLE_DIV 2
`define INTEGRATED_REQUEST_CONTROLLER_LEVEL_SAMPLES 2
`define INTEGRATED_REQUEST_CONTROLLER_EDGE_PRIOR_SAMPLES 1

`endif

// ### integrated_request_controller_cpu_model.sv
`timescale 1ns/1ps
// Processor trap acceptance as seen from the level lines
module integrated_request_controller_cpu_model (
    // Level lines and processor state
    input wire logic [3:0] request_level_lines,
    input wire logic trap_en,
    input wire logic [3:0] pil,
    // Interrupt taken
    output logic take
);
    // With traps enabled, taken above the current priority, or at level 15 whatever the priority
    assign take = trap_en && (request_level_lines > pil || request_level_lines == 4'hF);
endmodule

// ### integrated_request_controller_ctrl.sv
`timescale 1ns/1ps
`include "integrated_request_controller_consts.svh"
module integrated_request_controller_ctrl #(
    parameter int SAMPLE_DIV = `INTEGRATED_REQUEST_CONTROLLER_SAMPLE_DIV,
    parameter int LEVEL_SAMPLES = `INTEGRATED_REQUEST_CONTROLLER_LEVEL_SAMPLES,
    parameter int PRIOR_SAMPLES = `INTEGRATED_REQUEST_CONTROLLER_EDGE_PRIOR_SAMPLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Alternate space register port
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic [5:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Request inputs, bit n is channel n, bit 0 unused
    input wire logic [15:1] request_in,
    // Level lines to processor
    output logic [3:0] request_level_lines
);
    localparam int DW = $clog2(SAMPLE_DIV + 1);

    logic [15:0] trig_upper_reg, trig_upper_next; // Channels 8-15
    logic [15:0] trig_lower_reg, trig_lower_next; // Channels 1-7
    logic [15:0] mask_reg, mask_next; // Channel masks, bit 0 output mask
    logic [15:1] pend_reg, pend_next; // Request latch
    logic [3:0] level_reg, level_next; // Level latch
    logic [3:0] lines_reg, lines_next; // Masked level output
    logic [31:0] rdata_reg, rdata_next; // Read data
    logic [DW-1:0] div_reg, div_next; // Sample divider
    logic sample_en_reg, sample_en_next; // Sample enable pulse
    logic [15:1] hits; // Qualified triggers
    logic [3:0] enc; // Priority encoder output
    logic [15:0] wmask_view; // Mask applied to latch

    // Sample enable divider
    always_comb begin
        div_next = div_reg + 1'b1;
        sample_en_next = 1'b0;
        if (div_reg == DW'(SAMPLE_DIV - 1)) begin
            div_next = '0;
            sample_en_next = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div_reg <= '0;
            sample_en_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            sample_en_reg <= sample_en_next;
        end
    end

    // Per-channel qualifiers
    genvar gi;
    generate
        for (gi = 1; gi <= 15; gi++) begin : g_ch
            integrated_request_controller_chan_if chif();
            assign chif.sample_en = sample_en_reg;
            assign chif.request_in = request_in[gi];
            assign chif.mode = (gi >= 8) ? integrated_request_controller_pkg::integrated_request_controller_trig_t'(trig_upper_reg[2*(gi-8) +: 2])
                                         : integrated_request_controller_pkg::integrated_request_controller_trig_t'(trig_lower_reg[2*gi +: 2]);
            assign hits[gi] = chif.hit;
            integrated_request_controller_chan_qual #(
                .LEVEL_SAMPLES(LEVEL_SAMPLES),
                .PRIOR_SAMPLES(PRIOR_SAMPLES)
            ) u_qual (
                .clock(clock),
                .sys_rst(sys_rst),
                .ch(chif.qual)
            );
        end
    endgenerate

    // Priority encoder over unmasked pending channels
    always_comb begin
        wmask_view = {pend_reg, 1'b0} & ~mask_reg;
        enc = 4'h0;
        for (int i = 1; i <= 15; i++) begin
            if (wmask_view[i]) enc = 4'(i);
        end
    end

    // Register writes, latches and read mux
    always_comb begin
        trig_upper_next = trig_upper_reg;
        trig_lower_next = trig_lower_reg;
        mask_next = mask_reg;
        pend_next = pend_reg;
        level_next = level_reg;
        rdata_next = 32'h00000000;
        if (reg_sel && reg_wr) begin
            case (reg_addr)
                `INTEGRATED_REQUEST_CONTROLLER_OFF_TRIG_UPPER: trig_upper_next = reg_wdata[15:0];
                `INTEGRATED_REQUEST_CONTROLLER_OFF_TRIG_LOWER: trig_lower_next = {reg_wdata[15:2], 2'h0};
                `INTEGRATED_REQUEST_CONTROLLER_OFF_PEND_CLEAR: pend_next = pend_reg & ~reg_wdata[15:1];
                `INTEGRATED_REQUEST_CONTROLLER_OFF_MASK: mask_next = reg_wdata[15:0];
                default: ;
            endcase
        end
        pend_next = pend_next | hits;
        if (level_reg == 4'h0 || enc > level_reg) begin
            level_next = enc;
        end
        if (reg_sel && reg_wr && reg_addr == `INTEGRATED_REQUEST_CONTROLLER_OFF_LEVEL && reg_wdata[`INTEGRATED_REQUEST_CONTROLLER_LEVEL_CLR_BIT]) begin
            level_next = 4'h0;
        end
        if (reg_sel && !reg_wr) begin
            case (reg_addr)
                `INTEGRATED_REQUEST_CONTROLLER_OFF_PEND_VIEW: rdata_next = {16'h0000, pend_reg, 1'b0};
                `INTEGRATED_REQUEST_CONTROLLER_OFF_LEVEL: rdata_next = {28'h0000000, level_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
        lines_next = mask_next[`INTEGRATED_REQUEST_CONTROLLER_MASK_OUT_BIT] ? 4'h0 : level_next;
    end

    // Register state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            trig_upper_reg <= `INTEGRATED_REQUEST_CONTROLLER_RST_TRIG;
            trig_lower_reg <= `INTEGRATED_REQUEST_CONTROLLER_RST_TRIG;
            mask_reg <= `INTEGRATED_REQUEST_CONTROLLER_RST_MASK;
            pend_reg <= `INTEGRATED_REQUEST_CONTROLLER_RST_PEND;
            level_reg <= `INTEGRATED_REQUEST_CONTROLLER_RST_LEVEL;
            lines_reg <= 4'h0;
            rdata_reg <= 32'h00000000;
        end else begin
            trig_upper_reg <= trig_upper_next;
            trig_lower_reg <= trig_lower_next;
            mask_reg <= mask_next;
            pend_reg <= pend_next;
            level_reg <= level_next;
            lines_reg <= lines_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign request_level_lines = lines_reg;
endmodule

// ### integrated_request_controller_pkg.sv
package integrated_request_controller_pkg;
    // Per-channel trigger qualification
    typedef enum logic [1:0] {
        INTEGRATED_REQUEST_CONTROLLER_TRIG_HIGH = 2'h0,
        INTEGRATED_REQUEST_CONTROLLER_TRIG_LOW = 2'h1,
        INTEGRATED_REQUEST_CONTROLLER_TRIG_RISE = 2'h2,
        INTEGRATED_REQUEST_CONTROLLER_TRIG_FALL = 2'h3
    } integrated_request_controller_trig_t;
endpackage

// ### test_integrated_interrupt_request_ctrl.sv
`timescale 1ns/1ps
// Self-checking bench for the request controller
module test_integrated_interrupt_request_ctrl;
    logic clock, sys_rst, reg_sel, reg_wr, take;
    logic [5:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [15:1] request_in, req, msk, act;
    logic [3:0] request_level_lines;
    logic [15:0] seed;
    logic [1:0] md;
    int fail_count, n_checks;
    integrated_request_controller_ctrl dut (.clock(clock), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .request_in(request_in),
        .request_level_lines(request_level_lines));
    integrated_request_controller_cpu_model cpu (.request_level_lines(request_level_lines), .trap_en(1'b1), .pil(4'h0), .take(take));
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Highest set channel number
    function automatic logic [3:0] top(input logic [15:1] v);
        top = 4'h0;
        for (int i = 1; i < 16; i++) begin
            if (v[i]) top = i[3:0];
        end
    endfunction
    // Next pseudo-random word
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Compares one word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One register access, read data left in d
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_sel <= 1'b1;
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_sel <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(d, exp);
    endtask
    // Lets sampling and qualification finish
    task automatic settle;
        repeat (12) @(posedge clock);
    endtask
    task automatic final_report;
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        final_report;
    end
    initial begin
        {sys_rst, reg_sel, reg_wr, reg_addr, reg_wdata, request_in} = {1'b1, 55'h0};
        seed = 16'h5EB2;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        rchk(6'h08, 32'h0);
        rchk(6'h14, 32'h0);
        rchk(6'h00, 32'h0);
        // A one-cycle pulse is too short to qualify
        request_in <= 15'h4000;
        @(posedge clock);
        request_in <= 15'h0;
        settle;
        rchk(6'h08, 32'h0);
        // Corner then random request and mask sets
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(lfsr(seed));
            req = k == 0 ? 15'h0001 : k == 1 ? 15'h7FFF : seed[15:1];
            msk = k < 2 ? 15'h0 : seed[8:0] ^ seed[15:2];
            acc(1'b1, 6'h10, {16'h0, msk, 1'b0});
            request_in <= req;
            settle;
            rchk(6'h08, {16'h0, req, 1'b0});
            rchk(6'h14, {28'h0, top(req & ~msk)});
            chk({28'h0, request_level_lines}, {28'h0, top(req & ~msk)});
            chk({31'h0, take}, {31'h0, |top(req & ~msk)});
            acc(1'b1, 6'h10, {16'h0, msk, 1'b1});
            chk({28'h0, request_level_lines}, 32'h0);
            rchk(6'h08, {16'h0, req, 1'b0});
            request_in <= 15'h0;
            settle;
            acc(1'b1, 6'h0C, {16'h0, req & ~msk, 1'b0});
            rchk(6'h08, {16'h0, req & msk, 1'b0});
            acc(1'b1, 6'h0C, 32'hFFFF);
            acc(1'b1, 6'h14, 32'h10);
            acc(1'b1, 6'h10, 32'h0);
            rchk(6'h14, 32'h0);
        end
        // Every trigger mode on all channels
        for (int m = 0; m < 4; m++) begin
            md = m[1:0];
            act = md[0] ? 15'h0 : 15'h7FFF;
            request_in <= ~act;
            acc(1'b1, 6'h10, 32'hFFFF);
            acc(1'b1, 6'h00, {16'h0, {8{md}}});
            acc(1'b1, 6'h04, {16'h0, {7{md}}, 2'h0});
            acc(1'b1, 6'h0C, 32'hFFFF);
            acc(1'b1, 6'h14, 32'h10);
            acc(1'b1, 6'h10, 32'h0);
            settle;
            rchk(6'h08, 32'h0);
            rchk(6'h14, 32'h0);
            request_in <= act;
            settle;
            rchk(6'h08, 32'hFFFE);
            rchk(6'h14, 32'hF);
        end
        final_report;
    end
endmodule
